// File: logic/flash_row_program_protect.sv
// Purpose: Row program sequencer and block protection for the embedded array
// Assumes: CPU bus on the same clock, software runs from RAM and keeps the waits
// Notes:   Reads of the array return the erased value while it is busy
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_regs.svh"
module flash_row_program_protect
  import flash_prog_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] bus_addr_i,
  input  wire logic [7:0]  bus_wdata_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  output var  logic [7:0]  bus_rdata_o,
  output var  logic        array_ready_o,
  output var  logic        charge_pump_on_o
);
  localparam logic [5:0] RCV_CYC = 6'(`RECOVERY_CYCLES);

  array_ctrl_t ctrl_r;
  array_ctrl_t ctrl_nxt;
  logic [7:0]  protect_start_select_r;
  logic [15:0] lat_addr_r;
  logic [7:0]  lat_data_r;
  logic        lat_valid_r;
  logic [5:0]  rcv_cnt_r;
  logic        wr_ctl;
  logic        wr_arr;
  logic        lat_prot;
  logic        busy;

  array_link_if link ();

  function automatic logic in_array(input logic [15:0] a);
    in_array = (a >= `USER_ARRAY_LO && a <= `USER_ARRAY_HI) || (a >= `VECTOR_ARRAY_LO);
  endfunction

  function automatic logic [15:0] prot_start(input logic [7:0] f);
    prot_start = {`PROTECT_TOP_BITS, f[7:1], 7'h00};
  endfunction

  function automatic logic is_protected(input logic [7:0] f, input logic [15:0] a);
    is_protected = (f != `PROTECT_OFF) && (a >= prot_start(f));
  endfunction

  assign wr_ctl   = bus_wr_i && (bus_addr_i == `ARRAY_CONTROL_ADDR);
  assign wr_arr   = bus_wr_i && in_array(bus_addr_i);
  assign busy     = ctrl_r.program_select || ctrl_r.erase || ctrl_r.high_voltage_enable
                    || (rcv_cnt_r != 6'h00) || link.erase_busy;

  always_comb begin
    ctrl_nxt = ctrl_r;
    lat_prot = is_protected(protect_start_select_r, lat_addr_r);
    if (wr_ctl) begin
      ctrl_nxt.mass = bus_wdata_i[`CTL_MASS_BIT];
      if (!(bus_wdata_i[`CTL_PROGRAM_SELECT_BIT] && bus_wdata_i[`CTL_ERASE_BIT])
          && !(bus_wdata_i[`CTL_PROGRAM_SELECT_BIT] && ctrl_r.erase)
          && !(bus_wdata_i[`CTL_ERASE_BIT] && ctrl_r.program_select)) begin
        ctrl_nxt.program_select = bus_wdata_i[`CTL_PROGRAM_SELECT_BIT];
        ctrl_nxt.erase          = bus_wdata_i[`CTL_ERASE_BIT];
      end
      // Mass erase reaches the top page, so any protection refuses high voltage when mass is set in the same write that raises it
      if (ctrl_nxt.erase && ctrl_nxt.mass) begin
        lat_prot = (protect_start_select_r != `PROTECT_OFF);
      end
      if (!bus_wdata_i[`CTL_HIGH_VOLTAGE_BIT]) begin
        ctrl_nxt.high_voltage_enable = 1'b0;
      end else if (!ctrl_r.high_voltage_enable) begin
        ctrl_nxt.high_voltage_enable = (ctrl_nxt.program_select ^ ctrl_nxt.erase)
                                       && lat_valid_r && !lat_prot;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      protect_start_select_r <= `PROTECT_RESET;
    end else if (bus_wr_i && bus_addr_i == `PROTECT_START_ADDR) begin
      protect_start_select_r <= bus_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_addr_r  <= 16'h0000;
      lat_data_r  <= 8'h00;
      lat_valid_r <= 1'b0;
    end else if (wr_arr && (ctrl_r.program_select || ctrl_r.erase)) begin
      lat_addr_r  <= ctrl_r.high_voltage_enable ? lat_addr_r : bus_addr_i;
      lat_data_r  <= bus_wdata_i;
      lat_valid_r <= 1'b1;
    end else if (!ctrl_r.program_select && !ctrl_r.erase && !ctrl_r.high_voltage_enable) begin
      lat_valid_r <= 1'b0;
    end
  end

  assign link.prog_we    = wr_arr && ctrl_r.program_select
                           && ctrl_r.high_voltage_enable && lat_valid_r
                           && (bus_addr_i[15:`ROW_LSB] == lat_addr_r[15:`ROW_LSB])
                           && !is_protected(protect_start_select_r, bus_addr_i);
  assign link.prog_addr  = bus_addr_i[13:0];
  assign link.prog_data  = bus_wdata_i;
  assign link.erase_go   = wr_ctl && ctrl_r.erase && ctrl_r.high_voltage_enable
                           && !ctrl_nxt.erase;
  assign link.erase_mass = ctrl_r.mass;
  assign link.erase_page = lat_addr_r[13:`PAGE_LSB];
  assign link.rd_addr    = bus_addr_i[13:0];

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rcv_cnt_r <= 6'h00;
    end else if (ctrl_r.high_voltage_enable && !ctrl_nxt.high_voltage_enable) begin
      rcv_cnt_r <= RCV_CYC;
    end else if (rcv_cnt_r != 6'h00) begin
      rcv_cnt_r <= rcv_cnt_r - 6'h01;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      array_ready_o    <= 1'b0;
      charge_pump_on_o <= 1'b0;
    end else begin
      array_ready_o    <= !busy;
      charge_pump_on_o <= ctrl_nxt.high_voltage_enable;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_rdata_o <= 8'h00;
    end else if (bus_rd_i) begin
      if (bus_addr_i == `ARRAY_CONTROL_ADDR) begin
        bus_rdata_o <= {4'h0, ctrl_r};
      end else if (bus_addr_i == `PROTECT_START_ADDR) begin
        bus_rdata_o <= protect_start_select_r;
      end else if (in_array(bus_addr_i)) begin
        bus_rdata_o <= busy ? `ERASED_BYTE : link.rd_data;
      end else begin
        bus_rdata_o <= 8'h00;
      end
    end
  end

  flash_cell_array #(.AW(14)) u_cells (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .link      (link)
  );

  sequence pump_request_s;
    wr_ctl && bus_wdata_i[`CTL_HIGH_VOLTAGE_BIT] && !ctrl_r.high_voltage_enable;
  endsequence
  sequence pump_fall_s;
    ctrl_r.high_voltage_enable ##1 !ctrl_r.high_voltage_enable;
  endsequence

  pump_needs_select_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(ctrl_r.high_voltage_enable) |-> (ctrl_r.program_select ^ ctrl_r.erase))
    else $error("High voltage set without exactly one select");
  select_exclusive_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !(ctrl_r.program_select && ctrl_r.erase))
    else $error("Program and erase select both set");
  protect_refuse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (pump_request_s and lat_prot) |=> !ctrl_r.high_voltage_enable)
    else $error("High voltage set on protected address");
  zero_protects_all_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (protect_start_select_r == 8'h00) |-> !link.prog_we)
    else $error("Zero protect value left array open");
  ff_disables_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (pump_request_s and ((protect_start_select_r == `PROTECT_OFF) && lat_valid_r
      && (ctrl_nxt.program_select ^ ctrl_nxt.erase))) |=> ctrl_r.high_voltage_enable)
    else $error("All-ones protect value still protects");
  top_protected_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_arr && (bus_addr_i[15:`PAGE_LSB] == 9'h1FF)
      && (protect_start_select_r != `PROTECT_OFF)) |-> !link.prog_we)
    else $error("Top address not protected");
  idle_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_arr && !ctrl_r.program_select && !ctrl_r.erase) |-> !link.prog_we)
    else $error("Array written without a select");
  addr_latch_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_arr && ctrl_r.program_select && !ctrl_r.high_voltage_enable)
      |=> (lat_addr_r == $past(bus_addr_i)) && lat_valid_r)
    else $error("Program address not latched");
  row_bound_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    link.prog_we |-> (bus_addr_i[15:`ROW_LSB] == lat_addr_r[15:`ROW_LSB]))
    else $error("Program outside latched row");
  recovery_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    pump_fall_s |=> !array_ready_o [*8])
    else $error("Array ready during recovery");
  protect_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !(bus_wr_i && bus_addr_i == `PROTECT_START_ADDR) |=> $stable(protect_start_select_r))
    else $error("Protect register changed without a write");
  latch_needed_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (pump_request_s and !lat_valid_r) |=> !ctrl_r.high_voltage_enable)
    else $error("High voltage set before a row write");
  ready_low_busy_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (ctrl_r.program_select || ctrl_r.erase) |=> !array_ready_o)
    else $error("Array ready while a select is set");
endmodule
`default_nettype wire

// File: logic/flash_prog_regs.svh
// Purpose: Addresses, field positions, reset values and timing counts
// Assumes: 16-bit CPU address space, 40 MHz bus clock
// Notes:   Definitions only
`ifndef FLASH_PROG_REGS_SVH
`define FLASH_PROG_REGS_SVH

`define ARRAY_CONTROL_ADDR   16'hFE08
`define PROTECT_START_ADDR   16'hFE09
`define USER_ARRAY_LO        16'hC000
`define USER_ARRAY_HI        16'hEFFF
`define VECTOR_ARRAY_LO      16'hFFD0

`define CTL_PROGRAM_SELECT_BIT 0
`define CTL_ERASE_BIT          1
`define CTL_MASS_BIT           2
`define CTL_HIGH_VOLTAGE_BIT   3

`define PROTECT_RESET        8'h00
`define PROTECT_OFF          8'hFF
`define PROTECT_TOP_BITS     2'h3
`define ROW_LSB              6
`define PAGE_LSB             7

`define ERASED_BYTE          8'hFF
`define CLK_PERIOD_NS        25
`define RECOVERY_TIME_NS     1000
`define RECOVERY_CYCLES      ((`RECOVERY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: logic/flash_prog_pkg.sv
// Purpose: Shared types of the row programming block
// Assumes: Constants live in flash_prog_regs.svh
// Notes:   Types only
package flash_prog_pkg;
  typedef struct packed {
    logic high_voltage_enable;
    logic mass;
    logic erase;
    logic program_select;
  } array_ctrl_t;

  typedef enum logic {ARR_IDLE, ARR_ERASE} arr_state_t;
endpackage

// File: logic/array_link_if.sv
// Purpose: Link between the sequencer and the cell array
// Assumes: Single clock domain
// Notes:   Array index is the low 14 address bits
`timescale 1ns/1ps
`default_nettype none
interface array_link_if;
  logic [13:0] rd_addr;
  logic [7:0]  rd_data;
  logic        prog_we;
  logic [13:0] prog_addr;
  logic [7:0]  prog_data;
  logic        erase_go;
  logic        erase_mass;
  logic [6:0]  erase_page;
  logic        erase_busy;

  modport ctrl (output rd_addr, prog_we, prog_addr, prog_data, erase_go, erase_mass,
                erase_page, input rd_data, erase_busy);
  modport mem  (input rd_addr, prog_we, prog_addr, prog_data, erase_go, erase_mass,
                erase_page, output rd_data, erase_busy);
endinterface
`default_nettype wire

// File: logic/flash_cell_array.sv
// Purpose: Byte array with AND-only programming and page/mass erase
// Assumes: Erase writes one byte per clock
// Notes:   Cell contents have no reset
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_regs.svh"
module flash_cell_array
  import flash_prog_pkg::*;
#(
  parameter int AW = 14
) (
  input  wire logic  sys_clk_i,
  input  wire logic  rst_n_i,
  array_link_if.mem  link
);
  logic [7:0]    mem [0:(2**AW)-1];
  arr_state_t    state_r;
  logic [AW-1:0] cnt_r;
  logic          mass_r;
  logic          last;

  assign last            = mass_r ? (&cnt_r) : (&cnt_r[`PAGE_LSB-1:0]);
  assign link.rd_data    = mem[link.rd_addr];
  assign link.erase_busy = (state_r == ARR_ERASE);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ARR_IDLE;
      cnt_r   <= '0;
      mass_r  <= 1'b0;
    end else begin
      unique case (state_r)
        ARR_IDLE: begin
          if (link.erase_go) begin
            state_r <= ARR_ERASE;
            mass_r  <= link.erase_mass;
            cnt_r   <= link.erase_mass ? '0 : {link.erase_page, {`PAGE_LSB{1'b0}}};
          end
        end
        ARR_ERASE: begin
          cnt_r <= cnt_r + 1'b1;
          if (last) begin
            state_r <= ARR_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (state_r == ARR_ERASE) begin
      mem[cnt_r] <= `ERASED_BYTE;
    end else if (link.prog_we) begin
      mem[link.prog_addr] <= mem[link.prog_addr] & link.prog_data;
    end
  end

  property prog_and_p;
    logic [AW-1:0] a;
    logic [7:0] v;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    (link.prog_we && state_r == ARR_IDLE, a = link.prog_addr,
     v = mem[link.prog_addr] & link.prog_data) |=> (mem[a] == v);
  endproperty
  prog_only_clears_a: assert property (prog_and_p)
    else $error("Program changed a bit from zero to one");
endmodule
`default_nettype wire

// File: dv/cpu_host_model.sv
// Purpose: CPU bus master running the flash routines from RAM
// Assumes: One bus cycle per two clocks, changes just after rising edges
// Notes:   Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_regs.svh"
module cpu_host_model (
  input  wire logic        sys_clk_i,
  output var  logic [15:0] bus_addr_o,
  output var  logic [7:0]  bus_wdata_o,
  output var  logic        bus_wr_o,
  output var  logic        bus_rd_o,
  input  wire logic [7:0]  bus_rdata_i
);
  // Only data cycles are issued, no code is fetched from the array
  initial begin
    bus_addr_o  = 16'h0000;
    bus_wdata_o = 8'h00;
    bus_wr_o    = 1'b0;
    bus_rd_o    = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    bus_addr_o  <= a;
    bus_wdata_o <= d;
    bus_wr_o    <= 1'b1;
    @(posedge sys_clk_i);
    bus_wr_o    <= 1'b0;
    bus_wdata_o <= ~d;
    bus_addr_o  <= ~a;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    bus_addr_o <= a;
    bus_rd_o   <= 1'b1;
    @(posedge sys_clk_i);
    bus_rd_o   <= 1'b0;
    bus_addr_o <= ~a;
    #1;
    d = bus_rdata_i;
  endtask

  // Select, row write, setup wait, high voltage, setup wait
  task automatic open_op(input logic [7:0] ctl, input logic [15:0] a);
    wr(`ARRAY_CONTROL_ADDR, ctl);
    wr(a, 8'hFF);
    idle(400);
    wr(`ARRAY_CONTROL_ADDR, ctl | 8'h08);
    idle(200);
  endtask

  task automatic prog_byte(input logic [15:0] a, input logic [7:0] d);
    wr(a, d);
    idle(1200);
  endtask

  task automatic close_op();
    wr(`ARRAY_CONTROL_ADDR, 8'h08);
    idle(200);
    wr(`ARRAY_CONTROL_ADDR, 8'h00);
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Purpose: Self-checking bench of the row program and protect block
// Assumes: 40 MHz clock, bus master model drives the register bus
// Notes:   Register test first, then mass erase before any array access, since cells start unknown
`timescale 1ns/1ps
`default_nettype none
`include "flash_prog_regs.svh"
module tb_top;
  logic        sys_clk_i;
  logic        rst_n_i;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_rdata;
  logic        array_ready;
  logic        pump_on;
  int          mismatches;
  int          checks;

  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  flash_row_program_protect i_dut (
    .sys_clk_i       (sys_clk_i),
    .rst_n_i         (rst_n_i),
    .bus_addr_i      (bus_addr),
    .bus_wdata_i     (bus_wdata),
    .bus_wr_i        (bus_wr),
    .bus_rd_i        (bus_rd),
    .bus_rdata_o     (bus_rdata),
    .array_ready_o   (array_ready),
    .charge_pump_on_o(pump_on)
  );

  cpu_host_model i_host (
    .sys_clk_i  (sys_clk_i),
    .bus_addr_o (bus_addr),
    .bus_wdata_o(bus_wdata),
    .bus_wr_o   (bus_wr),
    .bus_rd_o   (bus_rd),
    .bus_rdata_i(bus_rdata)
  );

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host.rd(a, d);
    cmp_byte($sformatf("read %h", a), e, d);
  endtask

  task automatic wait_ready(input int n);
    int k;
    k = 0;
    while (array_ready !== 1'b1 && k < n) begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    cmp_bit("array_ready_o", 1'b1, array_ready);
    if (array_ready !== 1'b1) complete_run();
  endtask

  task automatic t_reg();
    chk_rd(`PROTECT_START_ADDR, 8'h00);
    i_host.wr(`PROTECT_START_ADDR, 8'hA5);
    chk_rd(`PROTECT_START_ADDR, 8'hA5);
    chk_rd(16'h1234, 8'h00);
  endtask

  task automatic t_erase();
    i_host.wr(`PROTECT_START_ADDR, 8'hFF);
    i_host.open_op(8'h06, 16'hC000);
    cmp_bit("charge_pump_on_o", 1'b1, pump_on);
    i_host.wr(`ARRAY_CONTROL_ADDR, 8'h0C);
    i_host.idle(16500);
    i_host.close_op();
    wait_ready(100);
    chk_rd(16'hC000, 8'hFF);
    chk_rd(16'hFFFF, 8'hFF);
  endtask

  task automatic t_prog();
    i_host.open_op(8'h01, 16'hC040);
    i_host.prog_byte(16'hC041, 8'h0F);
    i_host.prog_byte(16'hC041, 8'hF5);
    i_host.prog_byte(16'hC080, 8'h00);
    i_host.close_op();
    cmp_bit("array_ready_o", 1'b0, array_ready);
    chk_rd(16'hC041, 8'hFF);
    wait_ready(60);
    chk_rd(16'hC041, 8'h05);
    chk_rd(16'hC080, 8'hFF);
    chk_rd(16'hC040, 8'hFF);
    i_host.wr(16'hC041, 8'h00);
    chk_rd(16'hC041, 8'h05);
    i_host.open_op(8'h02, 16'hC041);
    i_host.close_op();
    wait_ready(60);
    chk_rd(16'hC041, 8'hFF);
  endtask

  task automatic t_lock();
    i_host.wr(`ARRAY_CONTROL_ADDR, 8'h03);
    chk_rd(`ARRAY_CONTROL_ADDR, 8'h00);
    i_host.wr(`ARRAY_CONTROL_ADDR, 8'h01);
    i_host.wr(`ARRAY_CONTROL_ADDR, 8'h02);
    chk_rd(`ARRAY_CONTROL_ADDR, 8'h01);
    i_host.wr(`ARRAY_CONTROL_ADDR, 8'h00);
    i_host.wr(`ARRAY_CONTROL_ADDR, 8'h08);
    cmp_bit("charge_pump_on_o", 1'b0, pump_on);
    i_host.wr(`ARRAY_CONTROL_ADDR, 8'h00);
    wait_ready(60);
  endtask

  task automatic t_protect();
    logic [7:0]  pv [6];
    logic [15:0] av [6];
    logic        ev [6];
    string       n;
    pv = '{8'h00, 8'h01, 8'h03, 8'h03, 8'hFE, 8'hFF};
    av = '{16'hEFFF, 16'hC000, 16'hC07F, 16'hC080, 16'hFFD0, 16'hFFFF};
    ev = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 6; i++) begin
      i_host.wr(`PROTECT_START_ADDR, pv[i]);
      i_host.open_op(8'h01, av[i]);
      n = $sformatf("pump %h/%h", pv[i], av[i]);
      cmp_bit(n, ev[i], pump_on);
      i_host.close_op();
      wait_ready(60);
    end
  endtask

  initial begin
    mismatches = 0;
    checks     = 0;
    rst_n_i    = 1'b0;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_reg();
    t_erase();
    t_prog();
    t_lock();
    t_protect();
    complete_run();
  end
endmodule
`default_nettype wire
